// *** verilog/txf_consts.svh ***
`ifndef TXF_CONSTS_SVH
`define TXF_CONSTS_SVH

// Register byte offsets
`define TXF_OFS_CTL 8'h08
`define TXF_OFS_VTYPE 8'h1C
`define TXF_OFS_WP 8'h20
`define TXF_OFS_SWP 8'h24
`define TXF_OFS_WLVL 8'h28
`define TXF_OFS_RP 8'h30
`define TXF_OFS_RSP 8'h34
`define TXF_OFS_RLVL 8'h38

// Control/test bit positions
`define TXF_B_VLAN_ON 25
`define TXF_B_VLAN_OFF 24
`define TXF_B_SWP_T_ON 18
`define TXF_B_SWP_T_OFF 17
`define TXF_B_SWP_STEP 16
`define TXF_B_WP_T_ON 14
`define TXF_B_WP_T_OFF 13
`define TXF_B_WP_STEP 12
`define TXF_B_RP_T_ON 10
`define TXF_B_RP_T_OFF 9
`define TXF_B_RP_STEP 8
`define TXF_B_CLR_UNR 6
`define TXF_B_CLR_DONE 5
`define TXF_B_CLR_PAR 4
`define TXF_B_OP_ON 3
`define TXF_B_OP_OFF 2
`define TXF_B_RST_CLR 1
`define TXF_B_RST_SET 0

// Reset values and sizes
`define TXF_VTYPE_RST 16'h8100
`define TXF_PTR_RST 7'h00
`define TXF_PTR_W 7
`define TXF_STATUS_QW 2
`define TXF_DEPTH 32
`define TXF_DATA_W 64

`endif

// *** verilog/txf_pkg.sv ***
/*
 Types shared by the tx_fifo_control_test block.
 Assumes txf_consts.svh is on the include path.
*/
package txf_pkg;
`include "txf_consts.svh"

	typedef logic [`TXF_PTR_W-1:0] qptr_t;

	typedef struct packed {
		logic [`TXF_DATA_W-1:0] data;
		logic last;
	} qword_t;

	typedef struct packed {
		logic vlan_on;
		logic swp_test;
		logic wp_test;
		logic rp_test;
		logic op_on;
		logic frst;
		logic [15:0] vlan_type;
		qptr_t wp;
		qptr_t swp;
		qptr_t rp;
		qptr_t rsp;
		logic irq_unr;
		logic irq_done;
		logic irq_par;
		logic wr_rdy;
		logic out_v;
		qword_t out_w;
		logic in_frame;
		logic rvalid;
		logic [31:0] rdata;
	} txf_state_t;

endpackage

// *** verilog/txf_queue.sv ***
/*
 Synchronous FIFO with valid/ready on both sides and a flush.
 Assumes one clock, a synchronous active-high reset and a clock enable.
*/
module txf_queue #(
	parameter int WIDTH = 65,
	parameter int DEPTH = 32
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_flush,
	input wire logic i_valid,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_ready,
	output logic o_valid,
	output logic [WIDTH-1:0] o_data,
	input wire logic i_ready,
	output logic [$clog2(DEPTH):0] o_count
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
			$error("txf_queue: DEPTH must be a power of two >= 2");
		end
	endgenerate

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} q_t;

	logic [WIDTH-1:0] mem [DEPTH];
	q_t s;
	q_t nx;
	logic push;
	logic pop;

	assign o_ready = (s.cnt != (AW+1)'(DEPTH));
	assign o_valid = (s.cnt != '0);
	assign o_data = mem[s.rp];
	assign o_count = s.cnt;
	assign push = i_valid && o_ready && !i_flush;
	assign pop = o_valid && i_ready && !i_flush;

	always_comb begin
		nx = s;
		if (push) begin
			nx.wp = AW'(s.wp + 1'b1);
		end
		if (pop) begin
			nx.rp = AW'(s.rp + 1'b1);
		end
		nx.cnt = (AW+1)'(s.cnt + push - pop);
		if (i_flush) begin
			nx = '0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s <= '0;
		end else if (i_ce) begin
			s <= nx;
		end
	end

	// Storage has no reset; occupancy alone says what is valid
	always_ff @(posedge i_clk) begin
		if (i_ce && push) begin
			mem[s.wp] <= i_data;
		end
	end
endmodule

// *** verilog/tx_mac_fifo_control.sv ***
/*
 Tx_fifo_control_test: qword queue filled by the buffer side and
 drained by the MAC transmitter, with control/test, pointer, level and
 VLAN Ethertype registers on a simple word register port.
 Assumes all inputs are synchronous to I_CLK_SYS and that the register
 port presents one access per cycle, read data one cycle later.
*/
// How it works
// - On/off pairs act on bits written 1; read 0b10 on, 0b01 off.
// - Bit 25 enables, bit 24 disables VLAN insertion; disabled after reset.
// - Bits 18/17 toggle tentative pointer test; bit 16 steps it.
// - Bits 14/13 toggle write pointer test; bit 12 steps it.
// - Bits 10/9 toggle read pointer test; bit 8 steps it.
// - Writing bit 6 clears pending underrun; reads zero.
// - Writing bit 5 clears pending transmission complete; reads zero.
// - Writing bit 4 clears pending parity error; reads zero.
// - Bits 3/2 turn operation on/off; off aborts activity; off after reset.
// - Bit 0 asserts, bit 1 releases FIFO reset; asserted after reset.
// - Ethertype register resets to 0x8100, MSB in bits 7:0.
// - Seven-bit write pointer in qwords, reset zero, test writable.
// - Seven-bit tentative write pointer in qwords, reset zero, test writable.
// - Level registers count qwords including two status qwords per packet.
// - Seven-bit read pointer in qwords, reset zero, test writable.
// - Seven-bit restart pointer in qwords, reset zero, test writable.
// - Frame sent successfully raises transmission complete event.
// - Queue empty while MAC drains a frame raises underrun event.
`include "txf_consts.svh"

module tx_mac_fifo_control
	import txf_pkg::*;
#(
	parameter int DEPTH = `TXF_DEPTH,
	parameter int STATUS_QW = `TXF_STATUS_QW
) (
	input wire logic I_CLK_SYS,
	input wire logic I_SYS_RST,
	input wire logic I_CE,
	input wire logic I_REG_WR,
	input wire logic I_REG_RD,
	input wire logic [7:0] I_REG_ADDR,
	input wire logic [31:0] I_REG_WDATA,
	output logic [31:0] O_REG_RDATA,
	output logic O_REG_RVALID,
	input wire logic I_WR_VALID,
	input wire logic [`TXF_DATA_W-1:0] I_WR_DATA,
	input wire logic I_WR_LAST,
	output logic O_WR_READY,
	output logic O_RD_VALID,
	output logic [`TXF_DATA_W-1:0] O_RD_DATA,
	output logic O_RD_LAST,
	input wire logic I_RD_READY,
	input wire logic I_MAC_TX_OK,
	output logic O_VLAN_EN,
	output logic [15:0] O_VLAN_TYPE,
	output logic O_IRQ_UNDERRUN,
	output logic O_IRQ_TX_DONE,
	output logic O_IRQ_PARITY
);
	localparam int CW = $clog2(DEPTH) + 1;
	localparam int QW = $bits(qword_t) + 1;

	generate
		if (DEPTH < 4 || DEPTH > 64) begin : g_bad_depth
			$error("tx_mac_fifo_control: DEPTH must lie in 4..64");
		end
		if (STATUS_QW < 0 || STATUS_QW > 8) begin : g_bad_status
			$error("tx_mac_fifo_control: STATUS_QW must lie in 0..8");
		end
	endgenerate

	// Next state of an on/off pair; the on bit wins a double write
	function automatic logic pair_next(input logic cur, input logic on, input logic off);
		if (on) begin
			pair_next = 1'b1;
		end else if (off) begin
			pair_next = 1'b0;
		end else begin
			pair_next = cur;
		end
	endfunction

	// Read-back image of a pair
	function automatic logic [1:0] pair_rd(input logic on);
		pair_rd = on ? 2'b10 : 2'b01;
	endfunction

	// Pointer arithmetic wraps at the seven-bit range
	function automatic qptr_t ptr_add(input qptr_t p, input qptr_t n);
		ptr_add = qptr_t'(p + n);
	endfunction

	function automatic qptr_t ptr_diff(input qptr_t a, input qptr_t b);
		ptr_diff = qptr_t'(a - b);
	endfunction

	function automatic txf_state_t reset_state();
		txf_state_t r;
		r = '0;
		r.frst = 1'b1;
		r.vlan_type = `TXF_VTYPE_RST;
		r.wp = `TXF_PTR_RST;
		r.swp = `TXF_PTR_RST;
		r.rp = `TXF_PTR_RST;
		r.rsp = `TXF_PTR_RST;
		reset_state = r;
	endfunction

	localparam qptr_t ONE_QW = qptr_t'(1);
	// A packet's last qword also accounts for its STATUS_QW stored status qwords
	localparam qptr_t LAST_QW = qptr_t'(STATUS_QW + 1);

	txf_state_t s;
	txf_state_t nx;
	txf_state_t held;
	logic run;
	logic run_n;
	logic wr_push;
	logic f_in_ready;
	logic f_out_ready;
	logic f_valid;
	logic [QW-1:0] f_in;
	logic [QW-1:0] f_out;
	logic [CW-1:0] f_count;
	logic [CW:0] room;
	logic pop;
	logic take;
	logic underrun;
	logic par_err;
	logic ctl_wr;
	logic [31:0] wd;
	qword_t in_w;

	assign run = s.op_on && !s.frst;
	assign wr_push = I_WR_VALID && s.wr_rdy;
	assign in_w = '{data: I_WR_DATA, last: I_WR_LAST};
	assign f_in = {^in_w, in_w};
	// Queue drains into the output register only while it is free or emptying
	assign f_out_ready = run && (!s.out_v || I_RD_READY);
	assign pop = f_valid && f_out_ready;
	assign take = s.out_v && I_RD_READY;
	assign par_err = pop && (^f_out);
	assign underrun = run && s.in_frame && I_RD_READY && !s.out_v;
	assign ctl_wr = I_REG_WR && (I_REG_ADDR == `TXF_OFS_CTL);
	assign wd = I_REG_WDATA;

	txf_queue #(
		.WIDTH(QW),
		.DEPTH(DEPTH)
	) u_queue (
		.i_clk(I_CLK_SYS),
		.i_rst(I_SYS_RST),
		.i_ce(I_CE),
		.i_flush(!run),
		.i_valid(wr_push),
		.i_data(f_in),
		.o_ready(f_in_ready),
		.o_valid(f_valid),
		.o_data(f_out),
		.i_ready(f_out_ready),
		.o_count(f_count)
	);

	always_comb begin
		nx = s;
		held = reset_state();
		room = '0;

		// Fill side: every qword advances the tentative pointer,
		// a packet end commits it to the write pointer
		if (wr_push) begin
			if (I_WR_LAST) begin
				nx.swp = ptr_add(s.swp, LAST_QW);
				nx.wp = ptr_add(s.swp, LAST_QW);
			end else begin
				nx.swp = ptr_add(s.swp, ONE_QW);
			end
		end

		// Drain side: restart pointer marks the start of the next packet
		if (take) begin
			nx.out_v = 1'b0;
			nx.in_frame = !s.out_w.last;
			if (s.out_w.last) begin
				nx.rp = ptr_add(s.rp, LAST_QW);
				nx.rsp = ptr_add(s.rp, LAST_QW);
			end else begin
				nx.rp = ptr_add(s.rp, ONE_QW);
			end
		end
		if (pop) begin
			nx.out_v = 1'b1;
			nx.out_w = f_out[QW-2:0];
		end

		// Flag clears first so a same-cycle event still sets the flag
		if (ctl_wr && wd[`TXF_B_CLR_UNR]) begin
			nx.irq_unr = 1'b0;
		end
		if (ctl_wr && wd[`TXF_B_CLR_DONE]) begin
			nx.irq_done = 1'b0;
		end
		if (ctl_wr && wd[`TXF_B_CLR_PAR]) begin
			nx.irq_par = 1'b0;
		end
		if (underrun) begin
			nx.irq_unr = 1'b1;
		end
		if (I_MAC_TX_OK && !s.frst) begin
			nx.irq_done = 1'b1;
		end
		if (par_err) begin
			nx.irq_par = 1'b1;
		end

		// Command bits; test steps act only while their test mode is on
		if (ctl_wr) begin
			nx.vlan_on = pair_next(s.vlan_on, wd[`TXF_B_VLAN_ON], wd[`TXF_B_VLAN_OFF]);
			nx.swp_test = pair_next(s.swp_test, wd[`TXF_B_SWP_T_ON], wd[`TXF_B_SWP_T_OFF]);
			nx.wp_test = pair_next(s.wp_test, wd[`TXF_B_WP_T_ON], wd[`TXF_B_WP_T_OFF]);
			nx.rp_test = pair_next(s.rp_test, wd[`TXF_B_RP_T_ON], wd[`TXF_B_RP_T_OFF]);
			nx.op_on = pair_next(s.op_on, wd[`TXF_B_OP_ON], wd[`TXF_B_OP_OFF]);
			nx.frst = pair_next(s.frst, wd[`TXF_B_RST_SET], wd[`TXF_B_RST_CLR]);
			if (s.swp_test && wd[`TXF_B_SWP_STEP]) begin
				nx.swp = ptr_add(s.swp, ONE_QW);
			end
			if (s.wp_test && wd[`TXF_B_WP_STEP]) begin
				nx.wp = ptr_add(s.wp, ONE_QW);
			end
			if (s.rp_test && wd[`TXF_B_RP_STEP]) begin
				nx.rp = ptr_add(s.rp, ONE_QW);
			end
		end

		// Direct pointer loads need the matching test mode; levels are
		// derived and take no write
		if (I_REG_WR) begin
			case (I_REG_ADDR)
				`TXF_OFS_VTYPE: nx.vlan_type = wd[15:0];
				`TXF_OFS_WP: begin
					if (s.wp_test) begin
						nx.wp = wd[`TXF_PTR_W-1:0];
					end
				end
				`TXF_OFS_SWP: begin
					if (s.swp_test) begin
						nx.swp = wd[`TXF_PTR_W-1:0];
					end
				end
				`TXF_OFS_RP: begin
					if (s.rp_test) begin
						nx.rp = wd[`TXF_PTR_W-1:0];
					end
				end
				`TXF_OFS_RSP: begin
					if (s.rp_test) begin
						nx.rsp = wd[`TXF_PTR_W-1:0];
					end
				end
				default: ;
			endcase
		end

		// Operation off drops the frame in flight
		if (!run) begin
			nx.out_v = 1'b0;
			nx.in_frame = 1'b0;
		end

		// Ready is registered, so grant only if the word accepted this
		// cycle still leaves a free slot for the one it may admit next
		run_n = nx.op_on && !nx.frst;
		room = (CW+1)'({1'b0, f_count} + {{CW{1'b0}}, wr_push});
		nx.wr_rdy = run_n && f_in_ready && (room < (CW+1)'(DEPTH - 1));

		// Register read returns one cycle after the request
		nx.rvalid = I_REG_RD;
		if (I_REG_RD) begin
			nx.rdata = '0;
			case (I_REG_ADDR)
				`TXF_OFS_CTL: begin
					nx.rdata[`TXF_B_VLAN_ON:`TXF_B_VLAN_OFF] = pair_rd(s.vlan_on);
					nx.rdata[`TXF_B_SWP_T_ON:`TXF_B_SWP_T_OFF] = pair_rd(s.swp_test);
					nx.rdata[`TXF_B_WP_T_ON:`TXF_B_WP_T_OFF] = pair_rd(s.wp_test);
					nx.rdata[`TXF_B_RP_T_ON:`TXF_B_RP_T_OFF] = pair_rd(s.rp_test);
					nx.rdata[`TXF_B_OP_ON:`TXF_B_OP_OFF] = pair_rd(s.op_on);
					nx.rdata[`TXF_B_RST_CLR:`TXF_B_RST_SET] = pair_rd(!s.frst);
				end
				`TXF_OFS_VTYPE: nx.rdata[15:0] = s.vlan_type;
				`TXF_OFS_WP: nx.rdata[`TXF_PTR_W-1:0] = s.wp;
				`TXF_OFS_SWP: nx.rdata[`TXF_PTR_W-1:0] = s.swp;
				`TXF_OFS_WLVL: nx.rdata[`TXF_PTR_W-1:0] = ptr_diff(s.swp, s.rsp);
				`TXF_OFS_RP: nx.rdata[`TXF_PTR_W-1:0] = s.rp;
				`TXF_OFS_RSP: nx.rdata[`TXF_PTR_W-1:0] = s.rsp;
				`TXF_OFS_RLVL: nx.rdata[`TXF_PTR_W-1:0] = ptr_diff(s.wp, s.rp);
				default: nx.rdata = '0;
			endcase
		end

		// FIFO reset holds every function at its reset value, but the
		// register port keeps answering so software can release it
		if (nx.frst) begin
			held.rvalid = nx.rvalid;
			held.rdata = nx.rdata;
			nx = held;
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			s <= reset_state();
		end else if (I_CE) begin
			s <= nx;
		end
	end

	assign O_REG_RDATA = s.rdata;
	assign O_REG_RVALID = s.rvalid;
	assign O_WR_READY = s.wr_rdy;
	assign O_RD_VALID = s.out_v;
	assign O_RD_DATA = s.out_w.data;
	assign O_RD_LAST = s.out_w.last;
	assign O_VLAN_EN = s.vlan_on;
	// Stored byte-swapped; driven out most significant byte first
	assign O_VLAN_TYPE = {s.vlan_type[7:0], s.vlan_type[15:8]};
	assign O_IRQ_UNDERRUN = s.irq_unr;
	assign O_IRQ_TX_DONE = s.irq_done;
	assign O_IRQ_PARITY = s.irq_par;
endmodule

// *** sim/txf_ctl_properties.sv ***
/*
 Port checker for the tx_fifo_control_test block.
 Assumes one clock, a synchronous reset and only the top module's ports.
*/
`include "txf_consts.svh"
module txf_ctl_check
	import txf_pkg::*;
#(
	parameter int DEPTH = 32,
	parameter int STATUS_QW = 2
) (
	input wire logic I_CLK_SYS,
	input wire logic I_SYS_RST,
	input wire logic I_CE,
	input wire logic I_REG_WR,
	input wire logic I_REG_RD,
	input wire logic [7:0] I_REG_ADDR,
	input wire logic [31:0] I_REG_WDATA,
	input wire logic O_REG_RVALID,
	input wire logic O_WR_READY,
	input wire logic O_RD_VALID,
	input wire logic I_RD_READY,
	input wire logic I_MAC_TX_OK,
	input wire logic O_VLAN_EN,
	input wire logic [15:0] O_VLAN_TYPE,
	input wire logic O_IRQ_UNDERRUN,
	input wire logic O_IRQ_TX_DONE,
	input wire logic O_IRQ_PARITY
);
	logic wr_ctl;
	logic frst_q;
	logic [15:0] vt_q;
	assign wr_ctl = I_CE && I_REG_WR && I_REG_ADDR == `TXF_OFS_CTL;
	// Mirror of the FIFO reset bit; set wins when both bits are written
	always_ff @(posedge I_CLK_SYS) begin
		vt_q <= {I_REG_WDATA[7:0], I_REG_WDATA[15:8]};
		if (I_SYS_RST || (wr_ctl && I_REG_WDATA[0]))
			frst_q <= 1'b1;
		else if (wr_ctl && I_REG_WDATA[1])
			frst_q <= 1'b0;
	end
	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (I_SYS_RST);
	sequence s_read;
		I_CE && I_REG_RD;
	endsequence
	sequence s_vlan_on;
		wr_ctl && I_REG_WDATA[25] && !I_REG_WDATA[0] && !frst_q;
	endsequence
	sequence s_done_event;
		I_CE && I_MAC_TX_OK && !frst_q && !(wr_ctl && I_REG_WDATA[0]);
	endsequence
	a_read_answer: assert property (s_read |=> O_REG_RVALID) else $error("read unanswered");
	a_no_spurious: assert property (I_CE && !I_REG_RD |=> !O_REG_RVALID) else $error("stray rvalid");
	a_vlan_enable: assert property (s_vlan_on |=> O_VLAN_EN) else $error("vlan not on");
	a_vlan_disable: assert property (wr_ctl && I_REG_WDATA[24] && !I_REG_WDATA[25] |=> !O_VLAN_EN)
		else $error("vlan not off");
	a_reset_holds: assert property (frst_q && $past(frst_q) |-> !O_VLAN_EN && !O_WR_READY && !O_RD_VALID
		&& O_VLAN_TYPE == 16'h0081) else $error("fifo reset not held");
	a_vtype_write: assert property (I_CE && I_REG_WR && I_REG_ADDR == `TXF_OFS_VTYPE && !frst_q
		|=> O_VLAN_TYPE == vt_q) else $error("ethertype wrong");
	a_done_set: assert property (s_done_event |=> O_IRQ_TX_DONE) else $error("done not set");
	a_done_clear: assert property (wr_ctl && I_REG_WDATA[5] && !I_MAC_TX_OK |=> !O_IRQ_TX_DONE)
		else $error("done not cleared");
	a_under_clear: assert property (wr_ctl && I_REG_WDATA[6] && !I_RD_READY |=> !O_IRQ_UNDERRUN)
		else $error("underrun not cleared");
	a_parity_clear: assert property (wr_ctl && I_REG_WDATA[4] |=> !O_IRQ_PARITY) else $error("parity kept");
	a_under_cause: assert property ($rose(O_IRQ_UNDERRUN) |-> $past(I_RD_READY) && !$past(O_RD_VALID))
		else $error("underrun without cause");
endmodule

bind tx_mac_fifo_control txf_ctl_check #(.DEPTH(DEPTH), .STATUS_QW(STATUS_QW)) u_check (
	.I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST), .I_CE(I_CE), .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD),
	.I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .O_REG_RVALID(O_REG_RVALID), .O_WR_READY(O_WR_READY),
	.O_RD_VALID(O_RD_VALID), .I_RD_READY(I_RD_READY), .I_MAC_TX_OK(I_MAC_TX_OK), .O_VLAN_EN(O_VLAN_EN),
	.O_VLAN_TYPE(O_VLAN_TYPE), .O_IRQ_UNDERRUN(O_IRQ_UNDERRUN), .O_IRQ_TX_DONE(O_IRQ_TX_DONE),
	.O_IRQ_PARITY(O_IRQ_PARITY));

// *** sim/txf_mac_model.sv ***
/*
 Behavioural MAC transmitter draining the queue.
 Assumes the bench stalls it through i_hold, changed at falling edges.
*/
module txf_mac_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_hold,
	input wire logic i_valid,
	input wire logic [63:0] i_data,
	input wire logic i_last,
	output logic o_ready,
	output logic o_tx_ok,
	output int o_words,
	output logic [63:0] o_data
);
	timeunit 1ns;
	timeprecision 1ns;
	assign o_ready = !i_hold;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_words <= 0;
			o_tx_ok <= 1'b0;
		end else begin
			// Every frame is sent without error once its last qword is taken
			o_tx_ok <= i_valid && o_ready && i_last;
			if (i_valid && o_ready) begin
				o_words <= o_words + 1;
				o_data <= i_data;
			end
		end
	end
endmodule

// *** sim/tx_mac_fifo_control_test.sv ***
/*
 Self-checking bench for the tx_fifo_control_test.
 Assumes one 20 MHz clock shared by the design and the MAC model.
*/
`include "txf_consts.svh"
module tx_mac_fifo_control_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, ce, wr, rd, wvalid, wlast, hold, rvalid, wready, rd_valid, rd_last, rd_ready, tx_ok;
	logic vlan_en, irq_unr, irq_done, irq_par;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [63:0] wdata64, rd_data, mac_data;
	logic [15:0] vtype;
	int mac_words, error_cnt, cmp_count;
	int t_on[3] = '{14, 18, 10};
	int t_step[3] = '{12, 16, 8};
	logic [7:0] t_ad[3] = '{`TXF_OFS_WP, `TXF_OFS_SWP, `TXF_OFS_RP};

	tx_mac_fifo_control u_dut (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_CE(ce), .I_REG_WR(wr), .I_REG_RD(rd),
		.I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
		.I_WR_VALID(wvalid), .I_WR_DATA(wdata64), .I_WR_LAST(wlast), .O_WR_READY(wready),
		.O_RD_VALID(rd_valid), .O_RD_DATA(rd_data), .O_RD_LAST(rd_last), .I_RD_READY(rd_ready),
		.I_MAC_TX_OK(tx_ok), .O_VLAN_EN(vlan_en), .O_VLAN_TYPE(vtype), .O_IRQ_UNDERRUN(irq_unr),
		.O_IRQ_TX_DONE(irq_done), .O_IRQ_PARITY(irq_par));
	txf_mac_model u_mac (.i_clk(clk), .i_rst(rst), .i_hold(hold), .i_valid(rd_valid), .i_data(rd_data),
		.i_last(rd_last), .o_ready(rd_ready), .o_tx_ok(tx_ok), .o_words(mac_words), .o_data(mac_data));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk);
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr = 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
		@(negedge clk);
		rd = 1'b1;
		addr = a;
		@(negedge clk);
		rd = 1'b0;
		check(64'(rvalid), 64'h1);
		check(64'(rdata), 64'(exp));
	endtask

	task automatic pointers(input logic [6:0] wp, swp, rp, rsp, wl, rl);
		reg_rd(`TXF_OFS_WP, {25'h0, wp});
		reg_rd(`TXF_OFS_SWP, {25'h0, swp});
		reg_rd(`TXF_OFS_RP, {25'h0, rp});
		reg_rd(`TXF_OFS_RSP, {25'h0, rsp});
		reg_rd(`TXF_OFS_WLVL, {25'h0, wl});
		reg_rd(`TXF_OFS_RLVL, {25'h0, rl});
	endtask

	// Holds the qword until the edge that samples ready high
	task automatic push(input logic [63:0] d, input logic l);
		int n;
		@(negedge clk);
		wvalid = 1'b1;
		wdata64 = d;
		wlast = l;
		n = 0;
		while (wready !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		check(64'(wready), 64'h1);
		@(negedge clk);
		wvalid = 1'b0;
	endtask

	task automatic complete_run();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#100us;
		error_cnt++;
		complete_run();
	end

	initial begin
		{rst, ce, wr, rd, wvalid, wlast, hold} = 7'b1100000;
		addr = 8'h00;
		wdata = 32'h0;
		wdata64 = 64'h0;
		error_cnt = 0;
		cmp_count = 0;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		reg_rd(`TXF_OFS_CTL, 32'h01022205);
		reg_rd(`TXF_OFS_VTYPE, 32'h00008100);
		check(64'(vtype), 64'h0081);
		pointers(7'h0, 7'h0, 7'h0, 7'h0, 7'h0, 7'h0);
		reg_wr(`TXF_OFS_CTL, 32'h02000000);
		check(64'(vlan_en), 64'h0);
		reg_wr(`TXF_OFS_CTL, 32'h0000000A);
		reg_rd(`TXF_OFS_CTL, 32'h0102220A);
		reg_wr(`TXF_OFS_CTL, 32'h02000000);
		check(64'(vlan_en), 64'h1);
		reg_rd(`TXF_OFS_CTL, 32'h0202220A);
		reg_wr(`TXF_OFS_VTYPE, 32'hFFFF88A8);
		check(64'(vtype), 64'hA888);
		reg_rd(`TXF_OFS_VTYPE, 32'h000088A8);
		// Clock enable low must freeze the register file as well
		ce = 1'b0;
		reg_wr(`TXF_OFS_VTYPE, 32'h00001234);
		ce = 1'b1;
		reg_rd(`TXF_OFS_VTYPE, 32'h000088A8);
		reg_wr(8'h40, 32'hFFFFFFFF);
		reg_rd(8'h40, 32'h0);
		reg_wr(`TXF_OFS_WLVL, 32'h7F);
		reg_wr(`TXF_OFS_WP, 32'h11);
		reg_rd(`TXF_OFS_WP, 32'h0);
		// Stalled frame: two data qwords plus two status qwords
		hold = 1'b1;
		push(64'hA5A5A5A5A5A5A5A5, 1'b0);
		push(64'h0123456789ABCDEF, 1'b1);
		pointers(7'h4, 7'h4, 7'h0, 7'h0, 7'h4, 7'h4);
		hold = 1'b0;
		repeat (10) @(negedge clk);
		check(64'(mac_words), 64'h2);
		check(mac_data, 64'h0123456789ABCDEF);
		check(64'(irq_done), 64'h1);
		pointers(7'h4, 7'h4, 7'h4, 7'h4, 7'h0, 7'h0);
		push(64'h1, 1'b0);
		repeat (4) @(negedge clk);
		check(64'(irq_unr), 64'h1);
		hold = 1'b1;
		reg_wr(`TXF_OFS_CTL, 32'h00000070);
		check(64'({irq_unr, irq_done, irq_par}), 64'h0);
		reg_rd(`TXF_OFS_CTL, 32'h0202220A);
		push(64'h2, 1'b0);
		reg_wr(`TXF_OFS_CTL, 32'h00000004);
		// The drain register is dropped one cycle after operation goes off
		@(negedge clk);
		check(64'({rd_valid, wready}), 64'h0);
		for (int i = 0; i < 3; i++) begin
			reg_wr(`TXF_OFS_CTL, 32'h1 << t_on[i]);
			reg_wr(t_ad[i], 32'hFFFFFF91);
			reg_rd(t_ad[i], 32'h11);
			reg_wr(`TXF_OFS_CTL, 32'h1 << t_step[i]);
			reg_rd(t_ad[i], 32'h12);
			reg_wr(`TXF_OFS_CTL, 32'h1 << (t_on[i] - 1));
			reg_wr(`TXF_OFS_CTL, 32'h1 << t_step[i]);
			reg_wr(t_ad[i], 32'h55);
			reg_rd(t_ad[i], 32'h12);
		end
		reg_wr(`TXF_OFS_CTL, 32'h00000400);
		reg_wr(`TXF_OFS_RSP, 32'h44);
		reg_rd(`TXF_OFS_RSP, 32'h44);
		reg_wr(`TXF_OFS_CTL, 32'h00000003);
		reg_rd(`TXF_OFS_CTL, 32'h01022205);
		reg_rd(`TXF_OFS_VTYPE, 32'h00008100);
		pointers(7'h0, 7'h0, 7'h0, 7'h0, 7'h0, 7'h0);
		complete_run();
	end
endmodule
